// [tb_tmr16_irq_presc.sv]
// Self-checking bench for the timer front end
`timescale 1ns/10ps
module tb_tmr16_irq_presc;
    import tmr16_pkg::*;
    logic            clk = 0, rst = 1, capt = 0, esel = 1, fb = 0, gie = 1;
    logic            mb;
    logic [3:0]      ack = 0, irq;
    logic [1:0][2:0] cs = {CS_DIV1024, CS_STOP};
    logic [1:0]      ext = 0, ten;
    tmr16_bus_t      b = '0;
    tmr16_cnt_t      c;
    logic [7:0]      d;
    logic [15:0]     capv, v, c0;
    int failures = 0, samples_checked = 0, seed = 36, cyc = 0, i, n;
    int div [5] = '{1, 1, 8, 64, 256};
    always #2 clk = ~clk;
    tmr16_irq_presc dut (.clk(clk), .rst(rst), .ce(1'b1), .bus(b),
        .rdata(d), .cnt(c), .waveform_mode_sel(4'h0),
        .force_match_a(1'b0), .force_match_b(fb), .match_a_event(),
        .match_b_event(mb), .clock_source_sel(cs), .ext_count_pin(ext),
        .timer_clk_en(ten), .capture_input_pin(capt), .acomp_out(1'b0),
        .acomp_capture_sel(1'b0), .capture_edge_sel(esel),
        .capture_value(capv), .global_irq_en(gie), .vec_ack(ack),
        .irq_req(irq));
    tmr16_cnt_model model (.clk(clk), .rst(rst), .tick(ten[1]), .cnt(c));
    task automatic chk(input logic [15:0] g, e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, w);
        @(negedge clk) b = '{a, w, 1'b1, 1'b0};
        @(negedge clk) b.wr = 0;
    endtask : wr
    // Back-to-back pair, high byte then low byte
    task automatic wr2(input logic [7:0] a, w, a2, w2);
        @(negedge clk) b = '{a, w, 1'b1, 1'b0};
        @(negedge clk) b = '{a2, w2, 1'b1, 1'b0};
        @(negedge clk) b.wr = 0;
    endtask : wr2
    task automatic rdr(input logic [7:0] a);
        @(negedge clk) b = '{a, 8'h00, 1'b0, 1'b1};
        @(negedge clk) b.rd = 0;
    endtask : rdr
    task automatic step(input int k);
        repeat (k) @(negedge clk);
    endtask : step
    task automatic gap(output int g);
        g = 0;
        while (ten[1] !== 1'b1) step(1);
        do begin step(1); g++; end while (ten[1] !== 1'b1 && g < 999);
    endtask : gap
    task automatic give_verdict;
        $display("checked=%0d bad=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin failures++; give_verdict(); end
    end
    initial begin
        step(5);
        rst = 0;
        rdr(ADDR_IRQ_MASK); chk(d, RST_IRQ_MASK);
        wr(ADDR_IRQ_MASK, 8'hff); rdr(ADDR_IRQ_MASK);
        chk(d, IRQ_USED_MASK);
        rdr(8'h00); chk(d, 8'h00);
        for (i = 0; i < 6; i++) begin
            v = 16'($random(seed));
            wr2(ADDR_CMPB_HIGH, v[15:8], ADDR_CMPB_LOW, v[7:0]);
            rdr(ADDR_CMPB_HIGH); chk(d, v[15:8]);
            rdr(ADDR_CMPB_LOW); chk(d, v[7:0]);
        end
        $display("regs done");
        for (i = 1; i < 5; i++) begin
            cs[1] = 3'(i);
            gap(n); gap(n); chk(16'(n), 16'(div[i]));
        end
        cs[1] = CS_DIV8; wr(ADDR_DIV_CTRL, 8'h81); step(2);
        c0 = c.count_value; step(40); chk(c.count_value, c0);
        wr(ADDR_DIV_CTRL, 8'h00); step(40);
        chk(16'(c.count_value != c0), 16'h1);
        wr(ADDR_DIV_CTRL, 8'h01);
        step(1);
        rdr(ADDR_DIV_CTRL); chk(d, 8'h00);
        $display("prescaler done");
        cs[1] = CS_STOP; step(2); c0 = c.count_value + 16'h0005;
        wr2(ADDR_CMPB_HIGH, c0[15:8], ADDR_CMPB_LOW, c0[7:0]);
        wr(ADDR_IRQ_FLAGS, 8'hff); cs[1] = CS_DIV1; n = 0;
        while (irq[IRQ_MATCH_B] !== 1'b1 && n < 50) begin step(1); n++; end
        chk(c.count_value, c0 + 16'h0001);
        cs[1] = CS_STOP; rdr(ADDR_IRQ_FLAGS); chk(d, 8'h04);
        gie = 0;
        step(1);
        chk(irq, 4'h0);
        gie = 1;
        @(negedge clk) ack = 4'h4;
        @(negedge clk) ack = 4'h0;
        chk(irq, 4'h0);
        @(negedge clk) fb = 1;
        @(negedge clk) fb = 0;
        chk(16'(mb), 16'h1);
        rdr(ADDR_IRQ_FLAGS); chk(d, 8'h00);
        $display("match done");
        @(negedge clk) capt = 1;
        step(4); chk(capv, c.count_value);
        rdr(ADDR_IRQ_FLAGS); chk(d, 8'h20);
        rdr(ADDR_CAPT_LOW); chk(d, c.count_value[7:0]);
        rdr(ADDR_CAPT_HIGH); chk(d, c.count_value[15:8]);
        wr(ADDR_IRQ_FLAGS, 8'h20); rdr(ADDR_IRQ_FLAGS); chk(d, 8'h00);
        esel = 0; step(1); capt = 0; step(4);
        rdr(ADDR_IRQ_FLAGS); chk(d, 8'h20);
        $display("capture done");
        // Pin held steady around each select change, first high half period 4, then low 12, high 6, low 6
        cs[1] = CS_EXT_RISE; step(6); c0 = c.count_value;
        ext[1] = 1; step(3); chk(c.count_value, c0);
        step(1); chk(c.count_value, c0 + 16'h0001);
        ext[1] = 0; step(6); chk(c.count_value, c0 + 16'h0001);
        cs[1] = CS_EXT_FALL; step(6); ext[1] = 1; step(6);
        chk(c.count_value, c0 + 16'h0001);
        ext[1] = 0; step(6); chk(c.count_value, c0 + 16'h0002);
        $display("pin done");
        give_verdict();
    end
endmodule : tb_tmr16_irq_presc

// [tmr16_cnt_model.sv]
// Counter unit stand-in driven by the timer clock enable
`timescale 1ns/10ps
module tmr16_cnt_model
    import tmr16_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Tick in, counter view out
    input  wire logic tick,
    output tmr16_cnt_t cnt
);
    logic [15:0] count_reg;
    always_ff @(posedge clk) begin
        if (rst) count_reg <= 16'h0000;
        else if (tick) count_reg <= count_reg + 16'h0001;
    end
    assign cnt = '{count_reg, 16'hffff, count_reg == 16'hffff,
                   count_reg == 16'h0000, count_reg == 16'hffff};
endmodule : tmr16_cnt_model

// [tmr16_irq_presc.sv]
// Timer compare B, capture, interrupt flags and shared prescaler
`timescale 1ns/10ps
// Contract
// - Compare B value checked against counter always; match drives irq and pin.
// - 16-bit writes and capture reads pass high byte through one shared temporary byte; compare B high reads direct.
// - Capture event copies counter into capture register; may act as top.
// - Mask holds capture, match B, match A, wrap enables; all gate requests.
// - Unused mask and flag bits read zero and ignore writes.
// - Capture flag on capture event, or at top when capture is top.
// - Flags clear on vector execution or writing one to their bit.
// - Match flags set in timer clock cycle after counter equals compare.
// - Forced compare strobes never set match flags.
// - Wrap flag on overflow in normal and CTC; else per waveform mode.
// - One prescaler serves both timers; each keeps its own clock select.
// - Select 1 is undivided clock; selects 2 to 5 pick divide by 8/64/256/1024.
// - Prescaler free runs; first prescaled count within 1 to N+1 clocks.
// - Prescaler reset restarts period for every attached timer.
// - External pin sampled each clock through synchroniser before edge detect.
// - Edge detector pulses on rising edge for select 7, falling for 6.
// - Pin edge reaches the timer clock enable after three system clocks and the counter after four.
// - External pin edges bypass the prescaler.
// - Divider reset bit self clears unless hold mode keeps it set.
// - Capture edge select: zero falling, one rising.
module tmr16_irq_presc
    import tmr16_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // Register bus
    input  wire tmr16_bus_t           bus,
    output logic [7:0]                rdata,
    // Counter unit hooks
    input  wire tmr16_cnt_t           cnt,
    input  wire logic [3:0]           waveform_mode_sel,
    input  wire logic                 force_match_a,
    input  wire logic                 force_match_b,
    output logic                      match_a_event,
    output logic                      match_b_event,
    // Clock selection, index 1 is the 16-bit timer
    input  wire logic [1:0][2:0]      clock_source_sel,
    input  wire logic [1:0]           ext_count_pin,
    output logic [1:0]                timer_clk_en,
    // Capture
    input  wire logic                 capture_input_pin,
    input  wire logic                 acomp_out,
    input  wire logic                 acomp_capture_sel,
    input  wire logic                 capture_edge_sel,
    output logic [15:0]               capture_value,
    // Interrupts
    input  wire logic                 global_irq_en,
    input  wire logic [3:0]           vec_ack,
    output logic [3:0]                irq_req
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]         mask_reg;
    logic [3:0]         flags_reg;
    logic [3:0]         flag_set;
    logic [3:0]         flag_clr;
    logic [3:0]         mask_vec;
    logic [15:0]        compare_b_reg;
    logic [15:0]        capture_reg;
    logic [7:0]         temp_reg;
    logic [7:0]         rdata_reg;
    logic [PRESC_W-1:0] presc_reg;
    logic [N_TAPS-1:0]  tap_hit;
    logic               hold_reg;
    logic               div_reset_reg;
    logic               capt_prev_reg;
    logic               capt_src;
    logic               capture_evt;
    logic               capt_is_top;
    logic               wrap_cond;
    logic               eq_a;
    logic               eq_b;
    logic               tick16;
    logic               match_a_reg;
    logic               match_b_reg;
    logic               wr_mask;
    logic               wr_flags;
    logic               wr_div;
    logic               wr_capt_low;

    function automatic logic [7:0] flags_to_reg(input logic [3:0] v);
        logic [7:0] r;
        r              = 8'h00;
        r[BIT_WRAP]    = v[IRQ_WRAP];
        r[BIT_MATCH_A] = v[IRQ_MATCH_A];
        r[BIT_MATCH_B] = v[IRQ_MATCH_B];
        r[BIT_CAPTURE] = v[IRQ_CAPTURE];
        return r;
    endfunction : flags_to_reg

    function automatic logic [3:0] reg_to_flags(input logic [7:0] r);
        logic [3:0] v;
        v              = 4'h0;
        v[IRQ_WRAP]    = r[BIT_WRAP];
        v[IRQ_MATCH_A] = r[BIT_MATCH_A];
        v[IRQ_MATCH_B] = r[BIT_MATCH_B];
        v[IRQ_CAPTURE] = r[BIT_CAPTURE];
        return v;
    endfunction : reg_to_flags

    assign wr_mask     = bus.wr && (bus.addr == ADDR_IRQ_MASK);
    assign wr_flags    = bus.wr && (bus.addr == ADDR_IRQ_FLAGS);
    assign wr_div      = bus.wr && (bus.addr == ADDR_DIV_CTRL);
    assign wr_capt_low = bus.wr && (bus.addr == ADDR_CAPT_LOW);
    assign tick16      = timer_clk_en[T16];
    assign eq_a        = (cnt.count_value == cnt.compare_a_value);
    assign eq_b        = (cnt.count_value == compare_b_reg);

    // ------------------------------------------------------------------
    // Shared prescaler
    // ------------------------------------------------------------------
    // Free running; only the divider reset touches it
    always_ff @(posedge clk) begin
        if (rst) begin
            presc_reg <= RST_PRESC;
        end else if (ce) begin
            if (div_reset_reg) begin
                presc_reg <= RST_PRESC;
            end else begin
                presc_reg <= presc_reg + 10'h001;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < N_TAPS; i++) begin
            tap_hit[i] = ((presc_reg & TAP_MASKS[i]) == TAP_MASKS[i]);
        end
    end

    // Reset bit lingers only while hold mode is set
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_reg      <= 1'b0;
            div_reset_reg <= 1'b0;
        end else if (ce) begin
            if (wr_div) begin
                hold_reg      <= bus.wdata[BIT_HOLD];
                div_reset_reg <= bus.wdata[BIT_DIV_RESET];
            end else if (!hold_reg) begin
                div_reset_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-timer clock selection
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N_TIMERS; g++) begin : g_timer
            logic edge_pulse;
            logic tick_next;
            logic tick_reg;

            tmr16_pin_edge u_pin_edge (
                .clk        (clk),
                .rst        (rst),
                .ce         (ce),
                .pin        (ext_count_pin[g]),
                .rise_sel   (clock_source_sel[g] == CS_EXT_RISE),
                .edge_pulse (edge_pulse)
            );

            // Each timer reads its own select from the shared taps
            always_comb begin
                case (clock_source_sel[g])
                    CS_STOP:     tick_next = 1'b0;
                    CS_DIV1:     tick_next = 1'b1;
                    CS_DIV8:     tick_next = tap_hit[0];
                    CS_DIV64:    tick_next = tap_hit[1];
                    CS_DIV256:   tick_next = tap_hit[2];
                    CS_DIV1024:  tick_next = tap_hit[3];
                    CS_EXT_FALL: tick_next = edge_pulse;
                    CS_EXT_RISE: tick_next = edge_pulse;
                    default:     tick_next = 1'b0;
                endcase
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    tick_reg <= 1'b0;
                end else if (ce) begin
                    tick_reg <= tick_next;
                end
            end

            assign timer_clk_en[g] = tick_reg;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    always_comb begin
        capt_is_top = 1'b0;
        case (waveform_mode_sel)
            4'h0, 4'h4:       wrap_cond = cnt.at_max;
            4'hc: begin
                wrap_cond   = cnt.at_max;
                capt_is_top = 1'b1;
            end
            4'h5, 4'h6, 4'h7, 4'hf: wrap_cond = cnt.at_top;
            4'he: begin
                wrap_cond   = cnt.at_top;
                capt_is_top = 1'b1;
            end
            4'h8, 4'ha: begin
                wrap_cond   = cnt.at_bottom;
                capt_is_top = 1'b1;
            end
            default:          wrap_cond = cnt.at_bottom;
        endcase
    end

    // ------------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------------
    assign capt_src    = acomp_capture_sel ? acomp_out : capture_input_pin;
    // Pin is disconnected while capture serves as top
    assign capture_evt = !capt_is_top &&
        (capture_edge_sel ? (capt_src && !capt_prev_reg)
                          : (!capt_src && capt_prev_reg));

    always_ff @(posedge clk) begin
        if (rst) begin
            capt_prev_reg <= 1'b0;
        end else if (ce) begin
            capt_prev_reg <= capt_src;
        end
    end

    // A CPU write beats a capture in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            capture_reg <= RST_CAPT;
        end else if (ce) begin
            if (wr_capt_low) begin
                capture_reg <= {temp_reg, bus.wdata};
            end else if (capture_evt) begin
                capture_reg <= cnt.count_value;
            end
        end
    end

    assign capture_value = capture_reg;

    // ------------------------------------------------------------------
    // Compare B and the shared high byte
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            temp_reg <= RST_TEMP;
        end else if (ce) begin
            if (bus.wr && (bus.addr == ADDR_CMPB_HIGH ||
                           bus.addr == ADDR_CAPT_HIGH)) begin
                temp_reg <= bus.wdata;
            end else if (bus.rd && bus.addr == ADDR_CAPT_LOW) begin
                temp_reg <= capture_reg[15:8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            compare_b_reg <= RST_CMPB;
        end else if (ce && bus.wr && bus.addr == ADDR_CMPB_LOW) begin
            compare_b_reg <= {temp_reg, bus.wdata};
        end
    end

    // Match strobes toward the waveform pins; forcing reaches only these
    always_ff @(posedge clk) begin
        if (rst) begin
            match_a_reg <= 1'b0;
            match_b_reg <= 1'b0;
        end else if (ce) begin
            match_a_reg <= (tick16 && eq_a) || force_match_a;
            match_b_reg <= (tick16 && eq_b) || force_match_b;
        end
    end

    assign match_a_event = match_a_reg;
    assign match_b_event = match_b_reg;

    // ------------------------------------------------------------------
    // Mask and flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_reg <= RST_IRQ_MASK;
        end else if (ce && wr_mask) begin
            mask_reg <= bus.wdata & IRQ_USED_MASK;
        end
    end

    always_comb begin
        flag_set              = 4'h0;
        flag_set[IRQ_WRAP]    = tick16 && wrap_cond;
        flag_set[IRQ_MATCH_A] = tick16 && eq_a;
        flag_set[IRQ_MATCH_B] = tick16 && eq_b;
        flag_set[IRQ_CAPTURE] = capt_is_top ? (tick16 && cnt.at_top)
                                            : capture_evt;
        flag_clr = vec_ack;
        if (wr_flags) begin
            flag_clr = flag_clr | reg_to_flags(bus.wdata);
        end
    end

    // A set in the clearing cycle survives
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_reg <= RST_IRQ_FLAGS;
        end else if (ce) begin
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end

    assign mask_vec = reg_to_flags(mask_reg);
    assign irq_req  = flags_reg & mask_vec & {4{global_irq_en}};

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (ce && bus.rd) begin
            case (bus.addr)
                ADDR_IRQ_MASK:  rdata_reg <= mask_reg;
                ADDR_IRQ_FLAGS: rdata_reg <= flags_to_reg(flags_reg);
                ADDR_CMPB_LOW:  rdata_reg <= compare_b_reg[7:0];
                ADDR_CMPB_HIGH: rdata_reg <= compare_b_reg[15:8];
                ADDR_CAPT_LOW:  rdata_reg <= capture_reg[7:0];
                ADDR_CAPT_HIGH: rdata_reg <= temp_reg;
                ADDR_DIV_CTRL: begin
                    rdata_reg                <= 8'h00;
                    rdata_reg[BIT_HOLD]      <= hold_reg;
                    rdata_reg[BIT_DIV_RESET] <= div_reset_reg;
                end
                default:        rdata_reg <= 8'h00;
            endcase
        end
    end

    assign rdata = rdata_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_hi_then_lo;
        (ce && bus.wr && bus.addr == ADDR_CMPB_HIGH)
        ##1 (ce && bus.wr && bus.addr == ADDR_CMPB_LOW);
    endsequence

    sequence s_rise_seen;
        ($rose(ext_count_pin[T16]) && ce &&
         clock_source_sel[T16] == CS_EXT_RISE)
        ##1 (ce && clock_source_sel[T16] == CS_EXT_RISE)[*2];
    endsequence

    property p_cmpb_pair;
        @(posedge clk) disable iff (rst)
        s_hi_then_lo |=> compare_b_reg == {$past(bus.wdata, 2),
                                           $past(bus.wdata)};
    endproperty
    a_cmpb_pair: assert property (p_cmpb_pair)
        else $error("compare B pair not committed");

    property p_match_b_flag;
        @(posedge clk) disable iff (rst)
        ce && tick16 && eq_b |=> flags_reg[IRQ_MATCH_B];
    endproperty
    a_match_b_flag: assert property (p_match_b_flag)
        else $error("match B flag missed");

    property p_force_no_flag;
        @(posedge clk) disable iff (rst)
        ce && force_match_b && !(tick16 && eq_b) &&
        !flags_reg[IRQ_MATCH_B] |=> !flags_reg[IRQ_MATCH_B] && match_b_event;
    endproperty
    a_force_no_flag: assert property (p_force_no_flag)
        else $error("forced compare set a flag");

    property p_set_beats_ack;
        @(posedge clk) disable iff (rst)
        ce && vec_ack[IRQ_WRAP] && flag_set[IRQ_WRAP] |=> flags_reg[IRQ_WRAP];
    endproperty
    a_set_beats_ack: assert property (p_set_beats_ack)
        else $error("wrap set lost to clear");

    property p_w1c;
        @(posedge clk) disable iff (rst)
        ce && wr_flags && bus.wdata[BIT_CAPTURE] && !flag_set[IRQ_CAPTURE]
        |=> !flags_reg[IRQ_CAPTURE];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("capture flag not cleared by write");

    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
        ce && bus.rd && (bus.addr == ADDR_IRQ_MASK ||
                         bus.addr == ADDR_IRQ_FLAGS)
        |=> (rdata & ~IRQ_USED_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit read nonzero");

    property p_irq_gate;
        @(posedge clk) disable iff (rst)
        irq_req[IRQ_MATCH_A] |-> global_irq_en &&
            mask_reg[BIT_MATCH_A] && flags_reg[IRQ_MATCH_A];
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("request without enable");

    property p_div_self_clear;
        @(posedge clk) disable iff (rst)
        ce && div_reset_reg && !hold_reg && !wr_div
        |=> !div_reset_reg && presc_reg == RST_PRESC ##1
            presc_reg == {9'h000, $past(ce)};
    endproperty
    a_div_self_clear: assert property (p_div_self_clear)
        else $error("divider reset did not release");

    property p_ext_edge;
        @(posedge clk) disable iff (rst)
        s_rise_seen |-> ##1 timer_clk_en[T16];
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("external edge not counted in time");

    property p_capture;
        @(posedge clk) disable iff (rst)
        ce && capture_evt && !wr_capt_low
        |=> capture_value == $past(cnt.count_value);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture value wrong");

endmodule : tmr16_irq_presc

// [tmr16_pin_edge.sv]
// External count pin sampler and edge detector
`timescale 1ns/10ps
module tmr16_pin_edge
    import tmr16_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // Pin and edge select
    input  wire logic pin,
    input  wire logic rise_sel,
    // Detected edge
    output logic      edge_pulse
);

    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;

    // Stage one feeds stage two only, to keep metastability contained
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else if (ce) begin
            sync1_reg <= pin;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // One pulse per chosen edge
    assign edge_pulse = rise_sel ? (sync2_reg & ~prev_reg)
                                 : (~sync2_reg & prev_reg);

endmodule : tmr16_pin_edge

// [tmr16_pkg.sv]
// Shared constants and carrier types for the 16-bit timer front end
package tmr16_pkg;

    // ------------------------------------------------------------------
    // Register addresses on the internal I/O bus
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h6f;
    localparam logic [7:0] ADDR_CMPB_LOW  = 8'h8a;
    localparam logic [7:0] ADDR_CMPB_HIGH = 8'h8b;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h3e;
    localparam logic [7:0] ADDR_CAPT_LOW  = 8'h90;
    localparam logic [7:0] ADDR_CAPT_HIGH = 8'h91;
    localparam logic [7:0] ADDR_DIV_CTRL  = 8'h43;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int BIT_WRAP      = 0;
    localparam int BIT_MATCH_A   = 1;
    localparam int BIT_MATCH_B   = 2;
    localparam int BIT_CAPTURE   = 5;
    localparam int BIT_DIV_RESET = 0;
    localparam int BIT_HOLD      = 7;

    localparam int IRQ_WRAP    = 0;
    localparam int IRQ_MATCH_A = 1;
    localparam int IRQ_MATCH_B = 2;
    localparam int IRQ_CAPTURE = 3;

    localparam logic [7:0]  IRQ_USED_MASK = 8'h27;
    localparam logic [7:0]  RST_IRQ_MASK  = 8'h00;
    localparam logic [3:0]  RST_IRQ_FLAGS = 4'h0;
    localparam logic [15:0] RST_CMPB      = 16'h0000;
    localparam logic [15:0] RST_CAPT      = 16'h0000;
    localparam logic [7:0]  RST_TEMP      = 8'h00;

    // ------------------------------------------------------------------
    // Clock select codes and prescaler taps
    // ------------------------------------------------------------------
    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_DIV1     = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV64    = 3'h3;
    localparam logic [2:0] CS_DIV256   = 3'h4;
    localparam logic [2:0] CS_DIV1024  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    localparam int          PRESC_W    = 10;
    localparam int          N_TAPS     = 4;
    localparam int          N_TIMERS   = 2;
    localparam int          T16        = 1;
    localparam logic [9:0]  RST_PRESC  = 10'h000;
    localparam logic [3:0][9:0] TAP_MASKS =
        {10'h3ff, 10'h0ff, 10'h03f, 10'h007};

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tmr16_bus_t;

    typedef struct packed {
        logic [15:0] count_value;
        logic [15:0] compare_a_value;
        logic        at_top;
        logic        at_bottom;
        logic        at_max;
    } tmr16_cnt_t;

endpackage : tmr16_pkg
